/* design/pmc_counters.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

module pmc_counters (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         reset_n_i,
	// CSR access port
	input  wire logic         csr_rd_i,
	input  wire logic         csr_wr_i,
	input  wire logic [11:0]  csr_addr_i,
	input  wire logic [31:0]  csr_wdata_i,
	output var  logic [31:0]  csr_rdata_o,
	// Core state
	input  wire logic         firmware_power_halt_state_i,
	input  wire logic         debug_halted_state_i,
	input  wire logic         dcsr_stopcount_i,
	input  wire logic         pause_active_i,
	input  wire logic         dma_event_i,
	// Event sources, two bits per event code
	input  wire logic [127:0] event_occ_i,
	input  wire logic [1:0]   retired_i,
	// Status
	output var  logic         counting_o
);

	typedef struct packed {
		pmc_pkg::pmc_cnt_type [3:0] hpm;
		pmc_pkg::pmc_evt_type [3:0] sel;
		pmc_pkg::pmc_cnt_type       cyc;
		pmc_pkg::pmc_cnt_type       ret;
		logic                       grp_en;
		logic [31:0]                rdata;
		logic                       counting;
	} pmc_state_type;

	pmc_state_type s_q;
	pmc_state_type s_d;
	logic [1:0]    evt_cnt [3:0];
	logic          run;
	logic [4:0]    slot;

	// ------------------------------------------------------------
	// Event selection
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_mux
			pmc_evt_if evt_if ();
			// each counter owns one selector mux
			assign evt_if.occ = event_occ_i;
			assign evt_if.sel = s_q.sel[g];
			assign evt_cnt[g] = evt_if.cnt;
			pmc_evt_mux u_mux (
				.evt (evt_if.mux_side)
			);
		end
	endgenerate

	function automatic pmc_pkg::pmc_evt_type clamp_evt(logic [31:0] v);
		if (v > 32'(`PMC_EVT_MAX)) begin
			clamp_evt = `PMC_EVT_MAX;
		end else begin
			clamp_evt = v[5:0];
		end
	endfunction

	function automatic logic [31:0] half(pmc_pkg::pmc_cnt_type c,
		logic hi);
		half = hi ? c[63:32] : c[31:0];
	endfunction

	function automatic pmc_pkg::pmc_cnt_type put_half(
		pmc_pkg::pmc_cnt_type c, logic hi, logic [31:0] v);
		put_half = hi ? {v, c[31:0]} : {c[63:32], v};
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// pause is no halt, counting goes on
		run = !firmware_power_halt_state_i &&
			!(debug_halted_state_i && dcsr_stopcount_i);
		s_d.counting = run;
		slot = csr_addr_i[4:0];
		if (run) begin
			s_d.cyc = s_q.cyc + 64'h1;
			s_d.ret = s_q.ret + 64'(retired_i);
		end
		// add count, wrap at 64 bits
		// DMA events are never counted, halted or running
		if (run && s_q.grp_en) begin
			for (int i = 0; i < 4; i++) begin
				s_d.hpm[i] = s_q.hpm[i] + 64'(evt_cnt[i]);
			end
		end
		// reads see the value before increment
		s_d.rdata = 32'h0;
		if (csr_rd_i) begin
			if (csr_addr_i == `PMC_CSR_GRP_EN) begin
				s_d.rdata = {31'h0, s_q.grp_en};
			end else if (csr_addr_i == `PMC_CSR_MCYCLE) begin
				s_d.rdata = half(s_q.cyc, 1'b0);
			end else if (csr_addr_i == `PMC_CSR_MCYCLEH) begin
				s_d.rdata = half(s_q.cyc, 1'b1);
			end else if (csr_addr_i == `PMC_CSR_MINSTRET) begin
				s_d.rdata = half(s_q.ret, 1'b0);
			end else if (csr_addr_i == `PMC_CSR_MINSTRETH) begin
				s_d.rdata = half(s_q.ret, 1'b1);
			end else if (slot >= `PMC_FIRST_SLOT &&
				slot <= `PMC_LAST_SLOT) begin
				if (csr_addr_i[11:5] == 7'h58) begin
					s_d.rdata = half(s_q.hpm[slot - 5'h3], 1'b0);
				end else if (csr_addr_i[11:5] == 7'h5c) begin
					s_d.rdata = half(s_q.hpm[slot - 5'h3], 1'b1);
				end else if (csr_addr_i[11:5] == 7'h19) begin
					s_d.rdata = {26'h0, s_q.sel[slot - 5'h3]};
				end
			end
		end
		// a counter write replaces the written half; the other half keeps this cycle's increment
		if (csr_wr_i) begin
			if (csr_addr_i == `PMC_CSR_GRP_EN) begin
				s_d.grp_en = csr_wdata_i[`PMC_GRP_EN_BIT];
			end else if (csr_addr_i == `PMC_CSR_MCYCLE) begin
				s_d.cyc = put_half(s_d.cyc, 1'b0, csr_wdata_i);
			end else if (csr_addr_i == `PMC_CSR_MCYCLEH) begin
				s_d.cyc = put_half(s_d.cyc, 1'b1, csr_wdata_i);
			end else if (csr_addr_i == `PMC_CSR_MINSTRET) begin
				s_d.ret = put_half(s_d.ret, 1'b0, csr_wdata_i);
			end else if (csr_addr_i == `PMC_CSR_MINSTRETH) begin
				s_d.ret = put_half(s_d.ret, 1'b1, csr_wdata_i);
			end else if (slot >= `PMC_FIRST_SLOT &&
				slot <= `PMC_LAST_SLOT) begin
				if (csr_addr_i[11:5] == 7'h58) begin
					s_d.hpm[slot - 5'h3] = put_half(
						s_d.hpm[slot - 5'h3], 1'b0, csr_wdata_i);
				end else if (csr_addr_i[11:5] == 7'h5c) begin
					s_d.hpm[slot - 5'h3] = put_half(
						s_d.hpm[slot - 5'h3], 1'b1, csr_wdata_i);
				end else if (csr_addr_i[11:5] == 7'h19) begin
					s_d.sel[slot - 5'h3] = clamp_evt(csr_wdata_i);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s_q        <= '0;
			s_q.grp_en <= `PMC_GRP_EN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign csr_rdata_o = s_q.rdata;
	assign counting_o  = s_q.counting;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	a_fw_halt_stops: assert property (
		firmware_power_halt_state_i && !csr_wr_i |=>
			s_q.cyc == $past(s_q.cyc))
		else $error("cycle counter moved in firmware halt");
	a_dbg_stop: assert property (
		debug_halted_state_i && dcsr_stopcount_i && !csr_wr_i |=>
			s_q.hpm == $past(s_q.hpm))
		else $error("event counters moved in stop-count halt");
	a_dbg_run: assert property (
		!firmware_power_halt_state_i && !debug_halted_state_i &&
		!csr_wr_i |=> s_q.cyc == $past(s_q.cyc) + 64'h1)
		else $error("cycle counter stalled while running");
	a_grp_gate: assert property (
		!s_q.grp_en && !csr_wr_i |=> s_q.hpm == $past(s_q.hpm))
		else $error("event counter moved with group disabled");
	a_grp_keep: assert property (
		csr_wr_i && csr_addr_i == `PMC_CSR_GRP_EN && !s_q.grp_en
		|=> s_q.hpm == $past(s_q.hpm))
		else $error("group write altered counters");
	a_grp_read: assert property (
		##1 csr_rdata_o[31:1] == 31'h0 || !$past(csr_rd_i) ||
		$past(csr_addr_i) != `PMC_CSR_GRP_EN)
		else $error("group control upper bits not zero");
	a_sel_clamp: assert property (
		s_q.sel[0] <= `PMC_EVT_MAX && s_q.sel[1] <= `PMC_EVT_MAX &&
		s_q.sel[2] <= `PMC_EVT_MAX && s_q.sel[3] <= `PMC_EVT_MAX)
		else $error("selector above highest event");
	a_high_slot: assert property (
		csr_rd_i && csr_addr_i[11:5] == 7'h58 && csr_addr_i[4:0] > 5'h6
		|=> csr_rdata_o == 32'h0)
		else $error("unused counter slot not zero");
	a_dma_halt: assert property (
		(firmware_power_halt_state_i ||
		debug_halted_state_i && dcsr_stopcount_i) && dma_event_i &&
		!csr_wr_i |=> s_q.hpm == $past(s_q.hpm) &&
		s_q.ret == $past(s_q.ret))
		else $error("DMA activity counted while halted");
	a_pause_run: assert property (
		pause_active_i && !firmware_power_halt_state_i &&
		!debug_halted_state_i && !csr_wr_i |=>
		s_q.cyc == $past(s_q.cyc) + 64'h1)
		else $error("cycle counter stalled during pause");

	c_count_run: cover property (s_q.grp_en && run ##1 s_q.grp_en);
	c_fw_halt: cover property (firmware_power_halt_state_i [*3]);
	c_sel_write: cover property (csr_wr_i &&
		csr_addr_i == `PMC_CSR_HPMEVT);

endmodule

`default_nettype wire

/* include/pmc_defs.svh */
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// CSR numbers of the counter space.
`define PMC_CSR_GRP_EN      12'h7d0
`define PMC_CSR_MCYCLE      12'hb00
`define PMC_CSR_MINSTRET    12'hb02
`define PMC_CSR_HPMCNT_LO   12'hb03
`define PMC_CSR_MCYCLEH     12'hb80
`define PMC_CSR_MINSTRETH   12'hb82
`define PMC_CSR_HPMCNT_HI   12'hb83
`define PMC_CSR_HPMEVT      12'h323

// Counter slots and event coding.
`define PMC_FIRST_SLOT      5'h03
`define PMC_LAST_SLOT       5'h06
`define PMC_LAST_CSR_SLOT   5'h1f
`define PMC_EVT_MAX         6'h2c
`define PMC_EVT_W           6
`define PMC_NUM_EVT         64

// Group control field and reset value.
`define PMC_GRP_EN_BIT      0
`define PMC_GRP_EN_RST      1'h1

`endif

/* include/pmc_pkg.sv */
package pmc_pkg;

	typedef logic [63:0] pmc_cnt_type;
	typedef logic [5:0]  pmc_evt_type;

	typedef enum logic [1:0] {
		PMC_RUN   = 2'b00,
		PMC_FWH   = 2'b01,
		PMC_DBH   = 2'b10
	} pmc_mode_type;

endpackage

/* include/pmc_evt_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface pmc_evt_if;
	logic [127:0] occ;
	logic [5:0]   sel;
	logic [1:0]   cnt;

	modport mux_side (input occ, input sel, output cnt);
	modport use_side (output occ, output sel, input cnt);
endinterface

`default_nettype wire

/* design/pmc_evt_mux.sv */
`timescale 1ns/1ns
`default_nettype none

// Picks the two-bit occurrence count of one selected event.
module pmc_evt_mux (
	pmc_evt_if.mux_side evt
);

	always_comb begin
		if (evt.sel == 6'h00) begin
			evt.cnt = 2'h0;
		end else begin
			evt.cnt = evt.occ[{evt.sel, 1'b0} +: 2];
		end
	end

endmodule

`default_nettype wire

/* test/pmc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Pipeline event source model
// ------------------------------------------------------------
module pmc_core_model (
	// Clock and activity request
	input  wire logic         clock_i,
	input  wire logic         act_i,
	// Event sources towards the counters
	output var  logic [127:0] occ_o,
	output var  logic [1:0]   retired_o,
	output var  logic         dma_o
);
	integer seed = 32'h172c79fa;

	initial begin
		occ_o = 128'h0;
		retired_o = 2'h0;
		dma_o = 1'b0;
	end

	// Quiet cycles carry no occurrences or retirements, so the bench can count exactly; dma_o stays random.
	always @(negedge clock_i) begin
		occ_o <= act_i ? {$random(seed), $random(seed), $random(seed),
			$random(seed)} : 128'h0;
		retired_o <= act_i ? 2'({$random(seed)} % 3) : 2'h0;
		dma_o <= 1'($random(seed));
	end
endmodule

`default_nettype wire

/* test/perf_monitor_counters_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end

module perf_monitor_counters_bench;
	logic        clock_i, reset_n_i, csr_rd_i, csr_wr_i, rd_seen;
	logic        fw, dbg, stop, pause, act, grp, dma, run_exp, counting_o;
	logic [11:0] csr_addr_i;
	logic [31:0] csr_wdata_i, csr_rdata_o, exp_v;
	logic [127:0] occ;
	logic [1:0]  ret;
	logic [63:0] ecnt [4];
	logic [63:0] iret, icyc;
	logic [5:0]  code [4] = '{6'h2c, 6'h00, 6'h17, 6'h01};
	logic [31:0] q [$];
	int          error_cnt, compares, cyc;

	pmc_counters dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.csr_rd_i(csr_rd_i), .csr_wr_i(csr_wr_i), .csr_addr_i(csr_addr_i),
		.csr_wdata_i(csr_wdata_i), .csr_rdata_o(csr_rdata_o),
		.firmware_power_halt_state_i(fw), .debug_halted_state_i(dbg),
		.dcsr_stopcount_i(stop), .pause_active_i(pause), .dma_event_i(dma),
		.event_occ_i(occ), .retired_i(ret), .counting_o(counting_o));
	pmc_core_model partner (.clock_i(clock_i), .act_i(act), .occ_o(occ),
		.retired_o(ret), .dma_o(dma));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic access(input logic r, w, input logic [11:0] a,
			input logic [31:0] d);
		csr_rd_i = r;
		csr_wr_i = w;
		csr_addr_i = a;
		csr_wdata_i = d;
		@(negedge clock_i);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		access(1'b1, 1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		if (a == `PMC_CSR_GRP_EN) grp = d[0];
		access(1'b0, 1'b1, a, d);
	endtask

	task automatic phase(input logic [3:0] m);
		{fw, dbg, stop, pause} = m;
		access(1'b0, 1'b0, 12'h0, 32'h0);
		act <= 1'b1;
		repeat (20) @(negedge clock_i);
		act <= 1'b0;
		access(1'b0, 1'b0, 12'h0, 32'h0);
	endtask

	// ------------------------------------------------------------
	// Expected counts and read-data monitor
	// ------------------------------------------------------------
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
		rd_seen <= csr_rd_i;
		run_exp <= reset_n_i && !fw && !(dbg && stop);
		if (reset_n_i && !fw && !(dbg && stop)) begin
			icyc = icyc + 64'h1;
			iret = iret + 64'(ret);
			for (int k = 0; k < 4; k++) begin
				if (grp && code[k] != 6'h0)
					ecnt[k] = ecnt[k] + 64'(occ[2*code[k] +: 2]);
			end
		end
	end

	always @(negedge clock_i) begin
		if (rd_seen === 1'b1) begin
			exp_v = q.pop_front();
			`CHK(csr_rdata_o, exp_v)
		end
		`CHK(counting_o, run_exp)
	end

	initial begin
		{reset_n_i, csr_rd_i, csr_wr_i, fw, dbg, stop, pause, act} = 8'h0;
		{csr_addr_i, csr_wdata_i, iret, icyc} = '0;
		grp = 1'b1;
		repeat (8) @(negedge clock_i);
		reset_n_i = 1'b1;
		rd(`PMC_CSR_GRP_EN, 32'h1);
		wr(`PMC_CSR_GRP_EN, 32'hffff_fffe);
		rd(`PMC_CSR_GRP_EN, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(`PMC_CSR_HPMEVT + 12'(k), k == 0 ? 32'h63 : 32'(code[k]));
			wr(`PMC_CSR_HPMCNT_LO + 12'(k), 32'hffff_fffe);
			wr(`PMC_CSR_HPMCNT_HI + 12'(k), 32'hffff_ffff);
			ecnt[k] = 64'hffff_ffff_ffff_fffe;
		end
		rd(`PMC_CSR_HPMEVT, 32'h2c);
		wr(12'h327, 32'h5);
		wr(12'hb07, 32'h5);
		rd(12'h327, 32'h0);
		rd(12'hb07, 32'h0);
		rd(12'h7d1, 32'h0);
		phase(4'b0000);
		wr(`PMC_CSR_GRP_EN, 32'h1);
		phase(4'b0000);
		phase(4'b1000);
		phase(4'b0110);
		phase(4'b0100);
		phase(4'b0001);
		wr(`PMC_CSR_GRP_EN, 32'h0);
		wr(`PMC_CSR_GRP_EN, 32'h1);
		wr(`PMC_CSR_GRP_EN, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rd(`PMC_CSR_HPMCNT_LO + 12'(k), ecnt[k][31:0]);
			rd(`PMC_CSR_HPMCNT_HI + 12'(k), ecnt[k][63:32]);
		end
		rd(`PMC_CSR_MINSTRET, iret[31:0]);
		rd(`PMC_CSR_MCYCLE, icyc[31:0]);
		rd(`PMC_CSR_MCYCLEH, icyc[63:32]);
		wr(`PMC_CSR_MCYCLE, 32'h10);
		icyc[31:0] = 32'h10;
		rd(`PMC_CSR_MCYCLE, icyc[31:0]);
		rd(12'hc01, 32'h0);
		access(1'b0, 1'b0, 12'h0, 32'h0);
		access(1'b0, 1'b0, 12'h0, 32'h0);
		report_and_stop();
	end
endmodule

`default_nettype wire
